// >>> rtl/sem_pkg.sv
/*
 constants shared by both ends of the serial memory command link.
 assumes a 250 mhz system clock on each end and a host-made shift clock.
*/
// Summary of operation
// - nine bit instruction, start one, opcode, address
// - host gives one clock before start bit
// - address picks one of sixteen words
// - 10xx read, 01xx write, 11xx erase
// - 0011 enables, 0000 disables programming
// - host enables programming before any programming
// - read works regardless of enable state
// - read sends zero dummy then sixteen bits
// - output changes on shift clock rising edge
// - output driven only during a read
// - programming starts at select falling edge
// - erase sets addressed word to ones
// - write takes sixteen data bits, preerased target
// - programming lasts while select low, 10-30 ms
// - host holds select high one period after programming
// - select low at least 1 us between instructions
// - 0010 erases all, ignored when bulk pin low
// - 0001 writes all, ignored when bulk pin low
// - shift clock may stop during programming pulse
// - program generator active only during programming; gen also runs for erase/write that prog_ok blocks
`default_nettype none
package sem_pkg;
  localparam int sem_words = 16;
  localparam int sem_width = 16;
  localparam int sem_clk_mhz = 250;
  localparam logic [3:0] sem_op_enable = 4'h3;
  localparam logic [3:0] sem_op_disable = 4'h0;
  localparam logic [3:0] sem_op_bulk_erase = 4'h2;
  localparam logic [3:0] sem_op_bulk_write = 4'h1;
  localparam logic [1:0] sem_op_read = 2'h2;
  localparam logic [1:0] sem_op_write = 2'h1;
  localparam logic [1:0] sem_op_erase = 2'h3;
  // host timing in its own units, then cycles
  localparam int sem_pulse_min_ms = 10;
  localparam int sem_sel_low_min_us = 1;
  localparam int sem_pulse_cycles = sem_pulse_min_ms * sem_clk_mhz * 1000;
  localparam int sem_sel_low_cycles = sem_sel_low_min_us * sem_clk_mhz;
  localparam logic [7:0] sem_half_period = 8'h40;
endpackage
`default_nettype wire

// >>> rtl/sem_link_if.sv
/*
 link between host and memory: select, shift clock, data in, data out.
 assumes the bench resolves nothing: output is a driven value plus enable.
*/
`timescale 1ns/100ps
`default_nettype none
interface sem_link_if;
  logic device_select;
  logic serial_shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  modport device (input device_select, serial_shift_clock, serial_in,
    output serial_out, serial_out_oe);
  modport host (output device_select, serial_shift_clock, serial_in,
    input serial_out, serial_out_oe);
endinterface
`default_nettype wire

// >>> rtl/sem_device.sv
/*
 memory end: decodes instructions and holds a sixteen word array.
 assumes link pins are asynchronous; each passes two flops first.
*/
`timescale 1ns/100ps
`default_nettype none
module sem_device (
  input wire logic clk_in,
  input wire logic resetn_in,
  sem_link_if.device link,
  input wire logic bulk_program_enable_pin_in,
  output logic programming_out,
  output logic program_enabled_out
);
  typedef enum logic [4:0] {
    sem_idle = 5'h01,
    sem_cmd = 5'h02,
    sem_data = 5'h04,
    sem_read = 5'h08,
    sem_prog = 5'h10
  } sem_dstate_t;
  typedef struct packed {
    logic [2:0] sel_s;
    logic [2:0] clk_s;
    logic [1:0] din_s;
    logic [1:0] bpe_s;
    sem_dstate_t st;
    logic [7:0] cmd;
    logic [3:0] cnt;
    logic [4:0] ocnt;
    logic [15:0] sh;
    logic [16:0] osh;
    logic wen;
    logic armed;
    logic pending;
    logic gen;
    logic dout;
    logic doe;
  } sem_dev_t;
  sem_dev_t r;
  sem_dev_t next_r;
  logic [15:0] mem [0:15];
  logic sel;
  logic rise;
  logic din;
  logic sel_fall;
  logic [3:0] op;
  logic prog_ok;
  assign sel = r.sel_s[1];
  assign din = r.din_s[1];
  assign rise = r.clk_s[1] & ~r.clk_s[2];
  assign sel_fall = ~r.sel_s[1] & r.sel_s[2];
  assign op = r.cmd[7:4];
  // bulk forms need the pin, all forms need enable
  assign prog_ok = r.wen & ((op[3:2] != 2'h0) | r.bpe_s[1]);
  always_comb begin
    next_r = r;
    next_r.sel_s = {r.sel_s[1:0], link.device_select};
    next_r.clk_s = {r.clk_s[1:0], link.serial_shift_clock};
    next_r.din_s = {r.din_s[0], link.serial_in};
    next_r.bpe_s = {r.bpe_s[0], bulk_program_enable_pin_in};
    next_r.dout = r.osh[16];
    if (!sel) begin
      next_r.doe = 1'b0;
      next_r.cnt = 4'h0;
      if (r.st == sem_prog && r.armed && sel_fall) begin
        next_r.gen = 1'b1;
        next_r.armed = 1'b0;
      end
      if (r.st != sem_prog) begin
        next_r.st = sem_idle;
      end
    end else begin
      case (r.st)
        sem_idle: begin
          if (rise && din) begin
            next_r.st = sem_cmd;
          end
        end
        sem_cmd: begin
          if (rise) begin
            next_r.cmd = {r.cmd[6:0], din};
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
              next_r.cnt = 4'h0;
              next_r.st = sem_prog;
              next_r.armed = 1'b0;
              if (r.cmd[6:5] == sem_pkg::sem_op_read) begin
                next_r.st = sem_read;
                next_r.osh = {1'b0, mem[{r.cmd[2:0], din}]};
                next_r.ocnt = 5'h0;
              end else if (r.cmd[6:3] == sem_pkg::sem_op_enable) begin
                next_r.wen = 1'b1;
                next_r.st = sem_idle;
              end else if (r.cmd[6:3] == sem_pkg::sem_op_disable) begin
                next_r.wen = 1'b0;
                next_r.st = sem_idle;
              end else if (r.cmd[6:5] == sem_pkg::sem_op_write ||
                  r.cmd[6:3] == sem_pkg::sem_op_bulk_write) begin
                next_r.st = sem_data;
              end else begin
                next_r.armed = 1'b1;
              end
            end
          end
        end
        sem_data: begin
          if (rise) begin
            next_r.sh = {r.sh[14:0], din};
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'hf) begin
              next_r.st = sem_prog;
              next_r.armed = 1'b1;
            end
          end
        end
        sem_read: begin
          next_r.doe = 1'b1;
          if (rise && r.ocnt != 5'h11) begin
            next_r.osh = {r.osh[15:0], 1'b0};
            next_r.ocnt = r.ocnt + 5'h1;
          end
        end
        sem_prog: begin
          // select high again ends the pulse; armed waits for the fall
          if (r.gen) begin
            next_r.pending = 1'b1;
            next_r.gen = 1'b0;
            next_r.armed = 1'b0;
            next_r.st = sem_idle;
          end
        end
        default: next_r.st = sem_idle;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '{st: sem_idle, default: '0};
    end else begin
      r <= next_r;
      if (r.gen && !sel && prog_ok) begin
        // array commits while the pulse stands; clock may stop
        if (op[3:2] == sem_pkg::sem_op_erase) begin
          mem[r.cmd[3:0]] <= 16'hffff;
        end else if (op[3:2] == sem_pkg::sem_op_write) begin
          mem[r.cmd[3:0]] <= r.sh;
        end else begin
          for (int i = 0; i < sem_pkg::sem_words; i++) begin
            mem[i] <= (op == sem_pkg::sem_op_bulk_erase) ? 16'hffff
              : r.sh;
          end
        end
      end
    end
  end
  assign link.serial_out = r.dout;
  assign link.serial_out_oe = r.doe;
  assign programming_out = r.gen;
  assign program_enabled_out = r.wen;
endmodule
`default_nettype wire

// >>> rtl/sem_host.sv
/*
 host end: makes the shift clock by division and sends one instruction.
 assumes a user pulse with opcode, address and data; link sampled twice.
*/
`timescale 1ns/100ps
`default_nettype none
module sem_host #(
  parameter int pulse_cycles = sem_pkg::sem_pulse_cycles
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  sem_link_if.host link,
  input wire logic start_in,
  input wire logic [3:0] opcode_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] data_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out
);
  typedef enum logic [4:0] {
    sem_h_idle = 5'h01,
    sem_h_pre = 5'h02,
    sem_h_shift = 5'h04,
    sem_h_pulse = 5'h08,
    sem_h_gap = 5'h10
  } sem_hstate_t;
  typedef struct packed {
    sem_hstate_t st;
    logic [7:0] div;
    logic [5:0] bits;
    logic [24:0] sh;
    logic [16:0] rsh;
    logic [1:0] dsync;
    logic [23:0] wait_cnt;
    logic rd;
    logic prog;
    logic sel;
    logic sk;
    logic dout;
    logic busy;
    logic done;
  } sem_host_t;
  sem_host_t r;
  sem_host_t next_r;
  logic tick;
  logic fall_tick;
  assign tick = (r.div == sem_pkg::sem_half_period - 8'h1);
  assign fall_tick = tick & r.sk;
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.dsync = {r.dsync[0], link.serial_out};
    next_r.div = tick ? 8'h0 : r.div + 8'h1;
    if (r.st == sem_h_pre || r.st == sem_h_shift) begin
      if (tick) begin
        next_r.sk = ~r.sk;
      end
    end else begin
      next_r.sk = 1'b0;
    end
    case (r.st)
      sem_h_idle: begin
        if (start_in) begin
          next_r.busy = 1'b1;
          next_r.rd = opcode_in[3:2] == sem_pkg::sem_op_read;
          next_r.prog = !(opcode_in[3:2] == sem_pkg::sem_op_read ||
            opcode_in == sem_pkg::sem_op_enable ||
            opcode_in == sem_pkg::sem_op_disable);
          next_r.sh = {1'b1, opcode_in, addr_in, data_in};
          if (opcode_in[3:2] == sem_pkg::sem_op_read) begin
            next_r.bits = 6'h1a;
          end else if (opcode_in[3:2] == sem_pkg::sem_op_write ||
              opcode_in == sem_pkg::sem_op_bulk_write) begin
            next_r.bits = 6'h19;
          end else begin
            next_r.bits = 6'h09;
          end
          next_r.sel = 1'b1;
          next_r.div = 8'h0;
          next_r.st = sem_h_pre;
        end
      end
      sem_h_pre: begin
        if (fall_tick) begin
          next_r.st = sem_h_shift;
          next_r.dout = r.sh[24];
          next_r.sh = {r.sh[23:0], 1'b0};
        end
      end
      sem_h_shift: begin
        if (tick && !r.sk) begin
          next_r.rsh = {r.rsh[15:0], r.dsync[1]};
        end
        if (fall_tick) begin
          next_r.bits = r.bits - 6'h1;
          next_r.dout = r.sh[24];
          next_r.sh = {r.sh[23:0], 1'b0};
          if (r.bits == 6'h1) begin
            // park data low so the next frame leads with zeros
            next_r.dout = 1'b0;
            next_r.sel = 1'b0;
            next_r.wait_cnt = '0;
            next_r.st = r.prog ? sem_h_pulse : sem_h_gap;
          end
        end
      end
      sem_h_pulse: begin
        next_r.wait_cnt = r.wait_cnt + 24'h1;
        if (r.wait_cnt == 24'(pulse_cycles)) begin
          next_r.sel = 1'b1;
          next_r.wait_cnt = '0;
          next_r.st = sem_h_gap;
        end
      end
      sem_h_gap: begin
        next_r.wait_cnt = r.wait_cnt + 24'h1;
        if (r.sel && r.wait_cnt == 24'(2 * sem_pkg::sem_half_period)) begin
          next_r.sel = 1'b0;
          next_r.wait_cnt = '0;
        end else if (!r.sel &&
            r.wait_cnt == 24'(sem_pkg::sem_sel_low_cycles)) begin
          next_r.st = sem_h_idle;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
      default: next_r.st = sem_h_idle;
    endcase
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '{st: sem_h_idle, default: '0};
    end else begin
      r <= next_r;
    end
  end
  assign link.device_select = r.sel;
  assign link.serial_shift_clock = r.sk;
  assign link.serial_in = r.dout;
  assign busy_out = r.busy;
  assign done_out = r.done;
  assign rdata_out = r.rsh[15:0];
endmodule
`default_nettype wire

// >>> bench/sem_link_chk.sv
/*
 checker on the link wires between host and memory ends.
 assumes one clock domain, async active low reset, 128-cycle shift period.
*/
`timescale 1ns/100ps
`default_nettype none
module sem_link_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic device_select,
  input wire logic serial_shift_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic sck_q;
  logic sel_q;
  logic [3:0] since_rise;
  logic [8:0] low_cnt;
  logic fell_seen;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // saturating counts keep the helpers small
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sck_q <= 1'b0;
      sel_q <= 1'b0;
      since_rise <= 4'hf;
      low_cnt <= 9'h000;
      fell_seen <= 1'b0;
    end else begin
      sck_q <= serial_shift_clock;
      sel_q <= device_select;
      if (serial_shift_clock && !sck_q)
        since_rise <= 4'h0;
      else if (since_rise != 4'hf)
        since_rise <= since_rise + 4'h1;
      if (device_select)
        low_cnt <= 9'h000;
      else if (low_cnt != 9'h1ff)
        low_cnt <= low_cnt + 9'h001;
      // gap only counts once a frame has ended
      if (!device_select && sel_q)
        fell_seen <= 1'b1;
    end
  end
  a_din_sck_low: assert property ($changed(serial_in) |-> !serial_shift_clock)
    else $error("data in changed while shift clock high");
  a_lead_zero: assert property ($rose(device_select) |-> (!serial_in)[*8])
    else $error("start bit sent before the leading shift clock");
  a_dummy_zero: assert property ($rose(serial_out_oe) |-> !serial_out)
    else $error("first read bit is not zero");
  a_out_after_rise: assert property ($changed(serial_out) && serial_out_oe
      && $past(serial_out_oe) |-> since_rise < 4'h8)
    else $error("read output changed away from a shift clock rise");
  a_oe_rise_sel: assert property ($rose(serial_out_oe) |-> device_select)
    else $error("output driven while not selected");
  a_oe_idle_off: assert property ((!device_select)[*5] |-> !serial_out_oe)
    else $error("output still driven after deselect");
  a_sel_high_hold: assert property ($rose(device_select)
      |-> device_select[*8])
    else $error("select high too short");
  a_gap_low: assert property ($rose(device_select) && fell_seen
      |-> low_cnt >= sem_pkg::sem_sel_low_cycles)
    else $error("select low gap under one microsecond");
endmodule
`default_nettype wire

// >>> bench/sem_bench.sv
/*
 bench joining host and memory ends; drives host user side, checks reads.
 assumes short programming pulse parameter and a 250 mhz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sem_bench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic bulk_pin = 1'b1;
  logic start = 1'b0;
  logic [3:0] opcode = 4'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] data = 16'h0000;
  logic busy, done, prog, enabled, prog_seen;
  logic [15:0] rdata;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  sem_link_if link_i ();
  sem_host #(.pulse_cycles(300)) sem_host_i (.clk_in(clk_in),
    .resetn_in(resetn_in), .link(link_i.host), .start_in(start),
    .opcode_in(opcode), .addr_in(addr), .data_in(data), .busy_out(busy),
    .done_out(done), .rdata_out(rdata));
  sem_device sem_device_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .link(link_i.device), .bulk_program_enable_pin_in(bulk_pin),
    .programming_out(prog), .program_enabled_out(enabled));
  sem_link_chk sem_link_chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .device_select(link_i.device_select),
    .serial_shift_clock(link_i.serial_shift_clock),
    .serial_in(link_i.serial_in), .serial_out(link_i.serial_out),
    .serial_out_oe(link_i.serial_out_oe));
  always #2 clk_in = ~clk_in;
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one whole instruction; notes whether a programming pulse was generated
  task automatic run(input logic [3:0] op, input logic [3:0] a,
      input logic [15:0] d);
    int n;
    @(posedge clk_in);
    start <= 1'b1;
    opcode <= op;
    addr <= a;
    data <= d;
    @(posedge clk_in);
    start <= 1'b0;
    prog_seen = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 6000) begin
      @(posedge clk_in);
      #1;
      if (prog === 1'b1)
        prog_seen = 1'b1;
      n++;
    end
    if (n >= 6000)
      fail_count++;
    check("idle after done", {15'h0000, busy}, 16'h0000);
  endtask
  task automatic rd(input logic [3:0] op, input logic [3:0] a,
      input logic [15:0] exp);
    run(op, a, 16'h0000);
    check("read data", rdata, exp);
    check("read pulse", {15'h0000, prog_seen}, 16'h0000);
  endtask
  // bound sized for about twenty instructions of some 4000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    run(4'h3, 4'ha, 16'h0000);
    check("enabled", {15'h0000, enabled}, 16'h0001);
    run(4'h2, 4'h0, 16'h0000);
    check("bulk erase pulse", {15'h0000, prog_seen}, 16'h0001);
    rd(4'h8, 4'h0, 16'hffff);
    rd(4'hb, 4'hf, 16'hffff);
    run(4'h7, 4'h5, 16'h1234);
    rd(4'ha, 4'h5, 16'h1234);
    rd(4'h9, 4'h6, 16'hffff);
    run(4'he, 4'h5, 16'h0000);
    rd(4'h8, 4'h5, 16'hffff);
    run(4'h4, 4'h2, 16'h00f0);
    // bulk ops must leave the array alone with the pin low
    @(posedge clk_in);
    bulk_pin <= 1'b0;
    run(4'h2, 4'h0, 16'h0000);
    rd(4'h8, 4'h2, 16'h00f0);
    run(4'h1, 4'h0, 16'h0000);
    rd(4'h8, 4'h6, 16'hffff);
    @(posedge clk_in);
    bulk_pin <= 1'b1;
    run(4'h2, 4'h0, 16'h0000);
    run(4'h1, 4'h0, 16'ha5c3);
    rd(4'h8, 4'h9, 16'ha5c3);
    run(4'h0, 4'h3, 16'h0000);
    check("disabled", {15'h0000, enabled}, 16'h0000);
    run(4'hd, 4'h9, 16'h0000);
    rd(4'h8, 4'h9, 16'ha5c3);
    run(4'h5, 4'h9, 16'h0000);
    rd(4'h8, 4'h9, 16'ha5c3);
    final_report();
  end
endmodule
`default_nettype wire
